// ---- rtl/enhanced_timer_compare_pwm.sv ----
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module enhanced_timer_compare_pwm (
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  input  wire logic                       timer_tick,
  input  wire logic [etm_pkg::ADDR_W-1:0] addr,
  input  wire logic [etm_pkg::DATA_W-1:0] wdata,
  input  wire logic                       wr_stb,
  input  wire logic                       rd_stb,
  output logic      [etm_pkg::DATA_W-1:0] rdata,
  output logic                            output_pin_a,
  output logic                            output_pin_a_oe,
  output logic                            output_pin_b,
  output logic                            output_pin_b_oe
);
  import etm_pkg::*;

  typedef struct packed {
    logic [7:0]       timer_control_one;
    logic [7:0]       timer_control_two;
    logic [2:0]       period_field;
    logic [CNT_W-1:0] cnt;
    dir_t             dir;
    logic [CNT_W-1:0] chan_a_compare_value;
    logic [CNT_W-1:0] chan_b_compare_value;
    logic [2:0]       flags;
    logic             run_prev;
    logic             pin_a;
    logic             pin_b;
    logic             oe_a;
    logic             oe_b;
    logic [7:0]       rdata;
  } state_t;

  state_t s_q;
  state_t s_d;

  function automatic logic apply_action(input logic [1:0] act,
                                        input logic       cur);
    unique case (act)
      ACT_NONE:   apply_action = cur;
      ACT_LOW:    apply_action = 1'b0;
      ACT_HIGH:   apply_action = 1'b1;
      ACT_TOGGLE: apply_action = ~cur;
    endcase
  endfunction : apply_action

  function automatic logic pwm_pin(input logic [1:0] act,
                                   input logic       wave,
                                   input logic       oc,
                                   input logic       inv);
    unique case (act)
      ACT_NONE:   pwm_pin = 1'b0;
      ACT_LOW:    pwm_pin = 1'b1;
      ACT_HIGH,
      ACT_TOGGLE: pwm_pin = (wave ~^ oc) ^ inv;
    endcase
  endfunction : pwm_pin

  // Field views
  logic [1:0]       chan_a_mode;
  logic [1:0]       chan_b_mode;
  logic [1:0]       act_a;
  logic [1:0]       act_b;
  logic             chan_a_output_control;
  logic             chan_b_output_control;
  logic             chan_a_invert;
  logic             chan_b_invert;
  logic             counter_clear_select;
  logic             counter_run;
  logic [1:0]       align_sel;
  logic             mode_cmp;
  logic             mode_timer;
  logic             mode_pwm;
  logic             centre;
  logic             step;
  logic             run_rise;
  logic [CNT_W-1:0] lim_cmp;
  logic [CNT_W-1:0] lim_pwm;
  logic [CNT_W-1:0] lim;
  logic             at_lim;
  logic             hit_a;
  logic             hit_b;
  logic             dir_ok;
  logic [2:0]       flag_set;
  logic [2:0]       flag_clr;
  logic [1:0]       wave;

  assign chan_a_mode = s_q.timer_control_one[POS_MODE+:2];
  assign chan_b_mode = s_q.timer_control_two[POS_MODE+:2];
  assign act_a       = s_q.timer_control_one[POS_ACTION+:2];
  assign act_b       = s_q.timer_control_two[POS_ACTION+:2];
  assign chan_a_output_control = s_q.timer_control_one[POS_OC];
  assign chan_b_output_control = s_q.timer_control_two[POS_OC];
  assign chan_a_invert         = s_q.timer_control_one[POS_INV];
  assign chan_b_invert         = s_q.timer_control_two[POS_INV];
  assign counter_clear_select  = s_q.timer_control_one[POS_CCLR];
  assign counter_run           = s_q.timer_control_one[POS_RUN];
  assign align_sel   = s_q.timer_control_two[POS_ALIGN+:2];

  assign mode_cmp   = (chan_a_mode == MODE_CMP)
                    && (chan_b_mode == MODE_CMP);
  assign mode_timer = (chan_a_mode == MODE_TIMER)
                    && (chan_b_mode == MODE_TIMER);
  assign mode_pwm   = (chan_a_mode == MODE_PWM)
                    && (chan_b_mode == MODE_PWM);
  assign centre     = mode_pwm && (align_sel != ALIGN_EDGE);
  assign step       = timer_tick && counter_run;
  assign run_rise   = counter_run && !s_q.run_prev;

  // Compare mode clears on the match point, zero field overflows
  assign lim_cmp = counter_clear_select ? s_q.chan_a_compare_value
                 : (s_q.period_field == 3'h0) ? 10'h3ff
                 : {s_q.period_field, 7'h00};
  // PWM top is period minus one; zero field wraps to 1024 counts
  assign lim_pwm = counter_clear_select
                 ? s_q.chan_a_compare_value - 10'd1
                 : {s_q.period_field - 3'd1, 7'h7f};
  assign lim     = mode_pwm ? lim_pwm : lim_cmp;
  assign at_lim  = s_q.cnt == lim;
  assign hit_a   = s_q.cnt == s_q.chan_a_compare_value;
  assign hit_b   = s_q.cnt == s_q.chan_b_compare_value;

  // Centre modes raise channel flags only in the chosen direction
  always_comb begin
    unique case (align_sel)
      ALIGN_EDGE: dir_ok = 1'b1;
      ALIGN_UP:   dir_ok = s_q.dir == DIR_UP;
      ALIGN_DOWN: dir_ok = s_q.dir == DIR_DOWN;
      default:    dir_ok = 1'b1;
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_wave
      pwm_wave u_wave (
        .cnt    (s_q.cnt),
        .lim    (lim_pwm),
        .duty   (g == 0 ? s_q.chan_a_compare_value
                        : s_q.chan_b_compare_value),
        .centre (centre),
        .down   (s_q.dir == DIR_DOWN),
        .top    (g == 1),
        .active (wave[g])
      );
    end
  endgenerate

  always_comb begin
    s_d          = s_q;
    flag_set     = 3'h0;
    flag_clr     = 3'h0;
    s_d.run_prev = counter_run;
    // Counter
    if (run_rise) begin
      s_d.cnt = RST_VALUE;
      s_d.dir = DIR_UP;
    end else if (step) begin
      if (!centre) begin
        s_d.cnt = at_lim ? RST_VALUE : s_q.cnt + 10'd1;
      end else if (s_q.dir == DIR_UP) begin
        if (at_lim) begin
          s_d.dir = DIR_DOWN;
        end else begin
          s_d.cnt = s_q.cnt + 10'd1;
        end
      end else begin
        if (s_q.cnt == RST_VALUE) begin
          s_d.dir = DIR_UP;
        end else begin
          s_d.cnt = s_q.cnt - 10'd1;
        end
      end
    end
    // Flags
    if (step && !run_rise) begin
      if (mode_pwm) begin
        flag_set[POS_FLAG_A] = hit_a && dir_ok;
        flag_set[POS_FLAG_B] = hit_b && dir_ok;
        flag_set[POS_FLAG_P] = centre
          ? (s_q.dir == DIR_DOWN && s_q.cnt == RST_VALUE)
          : at_lim;
      end else if (mode_cmp || mode_timer) begin
        flag_set[POS_FLAG_A] = hit_a;
        flag_set[POS_FLAG_B] = hit_b;
        flag_set[POS_FLAG_P] = at_lim && !counter_clear_select;
      end
    end
    // Pins
    s_d.oe_a = mode_cmp || (mode_pwm && !counter_clear_select);
    s_d.oe_b = mode_cmp || mode_pwm;
    if (mode_cmp) begin
      if (run_rise) begin
        s_d.pin_a = chan_a_output_control;
        s_d.pin_b = chan_b_output_control;
      end else begin
        if (flag_set[POS_FLAG_A]) begin
          s_d.pin_a = apply_action(act_a, s_q.pin_a);
        end
        if (flag_set[POS_FLAG_B]) begin
          s_d.pin_b = apply_action(act_b, s_q.pin_b);
        end
      end
    end else if (mode_pwm) begin
      s_d.pin_a = pwm_pin(act_a, wave[0], chan_a_output_control,
                          chan_a_invert);
      s_d.pin_b = pwm_pin(act_b, wave[1], chan_b_output_control,
                          chan_b_invert);
    end
    // Register writes; counter cannot be written
    if (wr_stb) begin
      unique case (addr)
        OFS_CTRL_ONE: s_d.timer_control_one = wdata;
        OFS_CTRL_TWO: s_d.timer_control_two = wdata;
        OFS_PERIOD:   s_d.period_field      = wdata[2:0];
        OFS_CCA_LO:   s_d.chan_a_compare_value[7:0] = wdata;
        OFS_CCA_HI:   s_d.chan_a_compare_value[9:8] = wdata[1:0];
        OFS_CCB_LO:   s_d.chan_b_compare_value[7:0] = wdata;
        OFS_CCB_HI:   s_d.chan_b_compare_value[9:8] = wdata[1:0];
        OFS_FLAGS:    flag_clr = wdata[2:0];
        default:      ;
      endcase
    end
    // Set wins over a clear in the same cycle
    s_d.flags = (s_q.flags & ~flag_clr) | flag_set;
    // Read data appears in the following cycle only
    s_d.rdata = 8'h00;
    if (rd_stb) begin
      unique case (addr)
        OFS_CTRL_ONE: s_d.rdata = s_q.timer_control_one;
        OFS_CTRL_TWO: s_d.rdata = s_q.timer_control_two;
        OFS_PERIOD:   s_d.rdata = {5'h00, s_q.period_field};
        OFS_CNT_LO:   s_d.rdata = s_q.cnt[7:0];
        OFS_CNT_HI:   s_d.rdata = {6'h00, s_q.cnt[9:8]};
        OFS_CCA_LO:   s_d.rdata = s_q.chan_a_compare_value[7:0];
        OFS_CCA_HI:   s_d.rdata = {6'h00, s_q.chan_a_compare_value[9:8]};
        OFS_CCB_LO:   s_d.rdata = s_q.chan_b_compare_value[7:0];
        OFS_CCB_HI:   s_d.rdata = {6'h00, s_q.chan_b_compare_value[9:8]};
        OFS_FLAGS:    s_d.rdata = {5'h00, s_q.flags};
        default:      s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q.timer_control_one    <= RST_CTRL;
      s_q.timer_control_two    <= RST_CTRL;
      s_q.period_field         <= RST_PERIOD;
      s_q.cnt                  <= RST_VALUE;
      s_q.dir                  <= DIR_UP;
      s_q.chan_a_compare_value <= RST_VALUE;
      s_q.chan_b_compare_value <= RST_VALUE;
      s_q.flags                <= 3'h0;
      s_q.run_prev             <= 1'b0;
      s_q.pin_a                <= 1'b0;
      s_q.pin_b                <= 1'b0;
      s_q.oe_a                 <= 1'b0;
      s_q.oe_b                 <= 1'b0;
      s_q.rdata                <= 8'h00;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata           = s_q.rdata;
  assign output_pin_a    = s_q.pin_a;
  assign output_pin_b    = s_q.pin_b;
  assign output_pin_a_oe = s_q.oe_a;
  assign output_pin_b_oe = s_q.oe_b;

  // Checks
  a_run_rise_load: assert property (@(posedge sys_clk) disable iff (rst)
    (mode_cmp && run_rise && !wr_stb) |=> (output_pin_a
      == $past(chan_a_output_control)))
    else $error("pin a not loaded at run start");

  a_zero_action_hold: assert property (@(posedge sys_clk) disable iff (rst)
    (mode_cmp && !run_rise && act_a == ACT_NONE) |=> $stable(output_pin_a))
    else $error("pin a moved with zero action");

  a_toggle_on_match: assert property (@(posedge sys_clk) disable iff (rst)
    (mode_cmp && !run_rise && step && hit_a && act_a == ACT_TOGGLE)
      |=> (output_pin_a != $past(output_pin_a)))
    else $error("pin a did not toggle on match");

  a_no_pflag_cclr: assert property (@(posedge sys_clk) disable iff (rst)
    (counter_clear_select && !mode_pwm && !s_q.flags[POS_FLAG_P]
      && !wr_stb) |=> !s_q.flags[POS_FLAG_P])
    else $error("period flag raised with clear select high");

  a_pflag_at_lim: assert property (@(posedge sys_clk) disable iff (rst)
    (mode_cmp && !counter_clear_select && step && !run_rise && at_lim)
      |=> (s_q.flags[POS_FLAG_P] && s_q.cnt == 10'h000))
    else $error("period match did not clear and flag");

  a_timer_no_drive: assert property (@(posedge sys_clk) disable iff (rst)
    mode_timer |-> ##1 (!output_pin_a_oe && !output_pin_b_oe))
    else $error("timer mode drives a pin");

  a_cnt_read_only: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_stb && (addr == OFS_CNT_LO || addr == OFS_CNT_HI) && !step
      && !run_rise) |=> $stable(s_q.cnt))
    else $error("counter changed by a write");

  a_centre_turn: assert property (@(posedge sys_clk) disable iff (rst)
    (centre && step && !run_rise && s_q.dir == DIR_UP && at_lim)
      |=> (s_q.dir == DIR_DOWN && $stable(s_q.cnt)))
    else $error("centre counter did not turn at the top");

  a_force_high: assert property (@(posedge sys_clk) disable iff (rst)
    (mode_pwm && act_b == ACT_LOW && !wr_stb) |=> ##1 output_pin_b)
    else $error("forced pin b not high");

  a_edge_wrap: assert property (@(posedge sys_clk) disable iff (rst)
    (mode_pwm && !centre && step && !run_rise && at_lim)
      |=> (s_q.cnt == 10'h000 && s_q.flags[POS_FLAG_P]))
    else $error("edge pwm did not wrap to zero");

  a_read_next_only: assert property (@(posedge sys_clk) disable iff (rst)
    !rd_stb |=> (rdata == 8'h00))
    else $error("read data outside its cycle");
endmodule : enhanced_timer_compare_pwm
`default_nettype wire

// ---- rtl/etm_pkg.sv ----
// Functional notes
// - Both mode fields zero select compare output
// - Clear-select low: period match clears, flags
// - Clear-select high: A match clears, no period flag
// - Compare pins follow only own channel match
// - Pin action: high, low or toggle
// - Run rising edge loads initial pin level
// - Pin action zero leaves pin unchanged
// - Timer mode counts, flags, leaves pins undriven
// - Mode fields 10 select PWM output
// - PWM clear-select high: A period, B duty
// - PWM clear-select low: period field times 128
// - Edge period field: 128..896, zero 1024
// - Edge A-register period equals A value
// - Centre field period doubled, duty 2x-1
// - Centre A-register period doubled, duty 2x-1
// - Edge PWM leading edges start at zero
// - Centre PWM channel centres are staggered
// - PWM raises A, B and period flags
// - Output control selects PWM active level
// - Pin action routes PWM or forces level
// - Invert bit inverts channel waveform
// - PWM keeps running while pin forced
// - Align field: edge, up, down, both
// - Ten-bit counter and compares, counter read-only
package etm_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 10;
  // Register offsets
  localparam logic [3:0] OFS_CTRL_ONE = 4'h0;
  localparam logic [3:0] OFS_CTRL_TWO = 4'h1;
  localparam logic [3:0] OFS_PERIOD   = 4'h2;
  localparam logic [3:0] OFS_CNT_LO   = 4'h3;
  localparam logic [3:0] OFS_CNT_HI   = 4'h4;
  localparam logic [3:0] OFS_CCA_LO   = 4'h5;
  localparam logic [3:0] OFS_CCA_HI   = 4'h6;
  localparam logic [3:0] OFS_CCB_LO   = 4'h7;
  localparam logic [3:0] OFS_CCB_HI   = 4'h8;
  localparam logic [3:0] OFS_FLAGS    = 4'h9;
  // Control field positions (bits 7:2 shared; bits 1:0 are clear-select and run in one, align in two)
  localparam int POS_MODE   = 6;
  localparam int POS_ACTION = 4;
  localparam int POS_OC     = 3;
  localparam int POS_INV    = 2;
  localparam int POS_CCLR   = 1;
  localparam int POS_RUN    = 0;
  localparam int POS_ALIGN  = 0;
  // Flag positions
  localparam int POS_FLAG_A = 0;
  localparam int POS_FLAG_B = 1;
  localparam int POS_FLAG_P = 2;
  // Reset values
  localparam logic [7:0] RST_CTRL   = 8'h00;
  localparam logic [2:0] RST_PERIOD = 3'h0;
  localparam logic [9:0] RST_VALUE  = 10'h000;
  // Mode and action codes
  localparam logic [1:0] MODE_CMP   = 2'h0;
  localparam logic [1:0] MODE_PWM   = 2'h2;
  localparam logic [1:0] MODE_TIMER = 2'h3;
  localparam logic [1:0] ACT_NONE   = 2'h0;
  localparam logic [1:0] ACT_LOW    = 2'h1;
  localparam logic [1:0] ACT_HIGH   = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
  localparam logic [1:0] ALIGN_EDGE = 2'h0;
  localparam logic [1:0] ALIGN_UP   = 2'h1;
  localparam logic [1:0] ALIGN_DOWN = 2'h2;
  // Period field step is 128 counts
  localparam int PERIOD_SHIFT = 7;
  typedef enum logic {
    DIR_UP   = 1'b0,
    DIR_DOWN = 1'b1
  } dir_t;
endpackage : etm_pkg

// ---- rtl/pwm_wave.sv ----
`timescale 1ns/1ps
`default_nettype none
module pwm_wave (
  input  wire logic [etm_pkg::CNT_W-1:0] cnt,
  input  wire logic [etm_pkg::CNT_W-1:0] lim,
  input  wire logic [etm_pkg::CNT_W-1:0] duty,
  input  wire logic                      centre,
  input  wire logic                      down,
  input  wire logic                      top,
  output logic                           active
);
  import etm_pkg::*;
  logic [CNT_W:0] c;
  logic [CNT_W:0] d;
  logic [CNT_W:0] thr;
  always_comb begin
    c   = {1'b0, cnt};
    d   = {1'b0, duty};
    thr = {1'b0, lim} - d;
    if (!centre) begin
      active = c < d;
    end else if (!top) begin
      // Up phase gives duty ticks, down phase one fewer
      active = down ? (c + 11'd1 < d) : (c < d);
    end else begin
      // Second channel centred on the turn at the top
      active = down ? (c > thr + 11'd1) : (c > thr);
    end
  end
endmodule : pwm_wave
`default_nettype wire

// ---- verification/enhanced_timer_compare_pwm_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module enhanced_timer_compare_pwm_tb;
  import etm_pkg::*;
  logic        sys_clk    = 1'b0;
  logic        rst        = 1'b1;
  logic        timer_tick = 1'b0;
  logic [3:0]  addr       = 4'h0;
  logic [7:0]  wdata      = 8'h00;
  logic        wr_stb     = 1'b0;
  logic        rd_stb     = 1'b0;
  logic        meas       = 1'b0;
  logic [7:0]  rdata;
  logic        pin_a, pin_a_oe, pin_b, pin_b_oe, lvl_a, lvl_b;
  logic [15:0] hi_a, hi_b, rs_a, rs_b;
  logic [15:0] both_q     = 16'h0000;
  logic [7:0]  d;
  int          err_total  = 0;
  int          num_checks = 0;

  always #50 sys_clk = ~sys_clk;

  enhanced_timer_compare_pwm u_enhanced_timer_compare_pwm (
    .sys_clk(sys_clk), .rst(rst), .timer_tick(timer_tick), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .output_pin_a(pin_a), .output_pin_a_oe(pin_a_oe),
    .output_pin_b(pin_b), .output_pin_b_oe(pin_b_oe));
  pin_load u_load_a (.sys_clk(sys_clk), .drive(pin_a), .drive_oe(pin_a_oe),
    .meas(meas), .level(lvl_a), .high_cnt(hi_a), .rise_cnt(rs_a));
  pin_load u_load_b (.sys_clk(sys_clk), .drive(pin_b), .drive_oe(pin_b_oe),
    .meas(meas), .level(lvl_b), .high_cnt(hi_b), .rise_cnt(rs_b));

  // Cycles with both pins high inside a window
  always @(posedge sys_clk) begin
    if (!meas) both_q <= 16'h0000;
    else if (lvl_a && lvl_b) both_q <= both_q + 16'h0001;
  end

  task automatic finish_test;
    if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    addr   <= a;
    wdata  <= v;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    #1 v = rdata;
  endtask : rd

  task automatic set_cmp(input logic [9:0] a, input logic [9:0] b);
    wr(OFS_CCA_LO, a[7:0]);
    wr(OFS_CCA_HI, {6'h00, a[9:8]});
    wr(OFS_CCB_LO, b[7:0]);
    wr(OFS_CCB_HI, {6'h00, b[9:8]});
  endtask : set_cmp

  task automatic start(input logic [7:0] c1, input logic [7:0] c2);
    wr(OFS_CTRL_ONE, 8'h00);
    wr(OFS_CTRL_TWO, c2);
    wr(OFS_FLAGS, 8'h07);
    wr(OFS_CTRL_ONE, c1);
  endtask : start

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      timer_tick <= 1'b1;
      @(posedge sys_clk);
      timer_tick <= 1'b0;
    end
    repeat (3) @(posedge sys_clk);
  endtask : ticks

  task automatic measure(input int settle, input int n);
    repeat (settle) @(posedge sys_clk);
    meas <= 1'b1;
    repeat (n) @(posedge sys_clk);
    meas <= 1'b0;
    #1;
  endtask : measure

  task automatic t_regs;
    rd(OFS_CTRL_ONE, d);
    check(d, 16'h0000);
    wr(OFS_CNT_LO, 8'h55);
    rd(OFS_CNT_LO, d);
    check(d, 16'h0000);
    wr(OFS_CCA_HI, 8'hff);
    rd(OFS_CCA_HI, d);
    check(d, 16'h0003);
    rd(4'ha, d);
    check(d, 16'h0000);
  endtask : t_regs

  task automatic t_compare;
    set_cmp(10'h00a, 10'h005);
    start(8'h3b, 8'h20);
    repeat (3) @(posedge sys_clk);
    check({pin_a, pin_b, pin_a_oe, pin_b_oe}, 16'h000b);
    ticks(6);
    check({pin_a, pin_b}, 16'h0003);
    rd(OFS_FLAGS, d);
    check(d, 16'h0002);
    ticks(5);
    check({pin_a, pin_b}, 16'h0001);
    rd(OFS_FLAGS, d);
    check(d, 16'h0003);
    rd(OFS_CNT_LO, d);
    check(d, 16'h0000);
    wr(OFS_FLAGS, 8'h07);
    wr(OFS_CTRL_ONE, 8'h0b);
    ticks(11);
    check({pin_a, pin_b}, 16'h0001);
    rd(OFS_FLAGS, d);
    check(d, 16'h0003);
  endtask : t_compare

  task automatic t_timer;
    set_cmp(10'h003, 10'h005);
    wr(OFS_PERIOD, 8'h01);
    start(8'hc1, 8'hc0);
    timer_tick <= 1'b1;
    repeat (150) @(posedge sys_clk);
    check({pin_a_oe, pin_b_oe}, 16'h0000);
    rd(OFS_FLAGS, d);
    check(d, 16'h0007);
  endtask : t_timer

  task automatic t_pwm_reg_period;
    set_cmp(10'h008, 10'h003);
    start(8'hab, 8'ha8);
    measure(20, 80);
    check(hi_b, 16'd30);
    check({15'h0000, pin_a_oe}, 16'h0000);
    wr(OFS_CTRL_TWO, 8'hac);
    measure(20, 80);
    check(hi_b, 16'd50);
    wr(OFS_CTRL_TWO, 8'ha0);
    measure(20, 80);
    check(hi_b, 16'd50);
    wr(OFS_CTRL_TWO, 8'h98);
    wr(OFS_FLAGS, 8'h07);
    measure(20, 80);
    check(hi_b, 16'd80);
    rd(OFS_FLAGS, d);
    check({8'h00, d & 8'h02}, 16'h0002);
    wr(OFS_CTRL_TWO, 8'h88);
    measure(20, 80);
    check(hi_b, 16'd0);
  endtask : t_pwm_reg_period

  task automatic t_pwm_field;
    set_cmp(10'h020, 10'h064);
    wr(OFS_PERIOD, 8'h01);
    start(8'ha9, 8'ha8);
    measure(130, 256);
    check(hi_a, 16'd64);
    check(hi_b, 16'd200);
    check(rs_a, 16'd2);
    check(rs_b, 16'd2);
    check(both_q, 16'd64);
    wr(OFS_FLAGS, 8'h07);
    repeat (130) @(posedge sys_clk);
    rd(OFS_FLAGS, d);
    check(d, 16'h0007);
    wr(OFS_PERIOD, 8'h00);
    start(8'ha9, 8'ha8);
    measure(1030, 1024);
    check(hi_a, 16'd32);
    check(hi_b, 16'd100);
  endtask : t_pwm_field

  task automatic t_centre;
    set_cmp(10'h020, 10'h00a);
    wr(OFS_PERIOD, 8'h01);
    for (int al = 1; al < 4; al++) begin
      start(8'ha9, 8'ha8 | 8'(al));
      // Clear flags on the way down, read them before the bottom
      repeat (150) @(posedge sys_clk);
      wr(OFS_FLAGS, 8'h07);
      repeat (96) @(posedge sys_clk);
      rd(OFS_FLAGS, d);
      check({8'h00, d}, (al == 1) ? 16'h0000 : 16'h0003);
      measure(300, 512);
      check(hi_a, 16'd126);
      check(hi_b, 16'd38);
      check(both_q, 16'd0);
    end
    set_cmp(10'h008, 10'h003);
    start(8'hab, 8'hab);
    measure(40, 160);
    check(hi_b, 16'd50);
  endtask : t_centre

  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_compare();
    t_timer();
    t_pwm_reg_period();
    t_pwm_field();
    t_centre();
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    finish_test();
  end
endmodule : enhanced_timer_compare_pwm_tb
`default_nettype wire

// ---- verification/pin_load.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_load (
  input  wire logic        sys_clk,
  input  wire logic        drive,
  input  wire logic        drive_oe,
  input  wire logic        meas,
  output logic             level,
  output logic      [15:0] high_cnt,
  output logic      [15:0] rise_cnt
);
  logic last_q = 1'b0;
  // Released pin is pulled low by the load
  assign level = drive_oe ? drive : 1'b0;
  always @(posedge sys_clk) begin
    last_q <= level;
    if (!meas) begin
      high_cnt <= 16'h0000;
      rise_cnt <= 16'h0000;
    end else begin
      high_cnt <= high_cnt + {15'h0000, level};
      rise_cnt <= rise_cnt + {15'h0000, level & ~last_q};
    end
  end
endmodule : pin_load
`default_nettype wire
